// ==== hw/daf_pkg.sv ====
package daf_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] REG_INFUNC = 8'h00;
  localparam logic [7:0] REG_ANASEL = 8'h04;
  localparam logic [7:0] REG_BBTIME = 8'h08;
  localparam logic [7:0] REG_SRCHLVL = 8'h0C;
  localparam logic [7:0] REG_GAINBIAS = 8'h10;
  localparam logic [7:0] REG_LOWLIM = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [7:0] REG_SYNC = 8'h1C;

  // ==========================================================================
  // contact function codes and fault setting fields
  localparam logic [7:0] FN_DCB = 8'h60;
  localparam logic [7:0] FN_SRCH_MAX = 8'h61;
  localparam logic [7:0] FN_SRCH_REF = 8'h62;
  localparam logic [7:0] FN_INT_CLR = 8'h65;
  localparam logic [7:0] FN_PID_OFF = 8'h66;
  localparam logic [3:0] EXT_FAULT_CODE_FIRST = 4'h2;
  localparam logic [3:0] EXT_FAULT_CODE_LAST = 4'h5;
  localparam int EF_NC_BIT = 0;
  localparam int EF_RUNONLY_BIT = 1;
  localparam logic [1:0] ACT_RAMP = 2'h0;
  localparam logic [1:0] ACT_COAST = 2'h1;
  localparam logic [1:0] ACT_ALT = 2'h2;
  localparam logic [1:0] ACT_MINOR = 2'h3;

  // ==========================================================================
  // analog function codes
  localparam logic [3:0] AN_GAIN = 4'h1;
  localparam logic [3:0] AN_BIAS1 = 4'h2;
  localparam logic [3:0] AN_BIAS2 = 4'h3;
  localparam logic [3:0] AN_LOWLIM = 4'hA;
  localparam logic [3:0] AN_MOTOR_OH = 4'hC;
  localparam int AN_FN_COUNT = 13;
  localparam int GAIN_FRAC = 12;
  localparam logic [15:0] THERM_TRIP_OHM = 16'h0532;
  localparam logic [15:0] THERM_REL_OHM = 16'h0226;

  // ==========================================================================
  // timing
  localparam int CLK_HZ = 20_000_000;
  localparam real ALARM_HOLD_SEC = 0.5;
  localparam int ALARM_HOLD_CYC = int'($ceil(ALARM_HOLD_SEC * CLK_HZ));

  typedef enum logic [2:0] {
    S_IDLE   = 3'h1,
    S_BBWAIT = 3'h2,
    S_SEARCH = 3'h4
  } daf_srch_t;
endpackage

// ==== hw/daf_aux_top.sv ====
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module daf_aux_top #(
  parameter logic [23:0] ALARM_HOLD_CYC = 24'(daf_pkg::ALARM_HOLD_CYC)
) (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  contact,
  input  wire logic        running,
  input  wire logic        run_cmd,
  input  wire logic        jog_cmd,
  input  wire logic        baseblock,
  input  wire logic        fault_reset,
  input  wire logic        power_loss_mode,
  input  wire logic [15:0] out_current,
  input  wire logic [15:0] out_freq,
  input  wire logic [15:0] freq_ref,
  input  wire logic [15:0] max_freq,
  input  wire logic [15:0] setpoint,
  input  wire logic [15:0] pid_out,
  input  wire logic [15:0] analog_in,
  input  wire logic [15:0] thermistor_ohms,
  output logic [3:0]       fault_show,
  output logic [3:0]       alarm_blink,
  output logic             fault_relay,
  output logic [2:0]       stop_sel,
  output logic             retry_inhibit,
  output logic             dc_brake,
  output logic             output_off,
  output logic             search_active,
  output logic [15:0]      search_start_freq,
  output logic [15:0]      sync_freq,
  output logic             sync_done,
  output logic             pid_int_clear,
  output logic             pid_bypass,
  output logic [15:0]      freq_ref_out,
  output logic [12:0]      analog_fn,
  output logic [15:0]      eff_gain,
  output logic [15:0]      eff_bias,
  output logic [15:0]      eff_low_limit,
  output logic             motor_overheat
);

  typedef struct packed {
    logic [3:0][7:0]    infunc;
    logic [3:0]         anasel;
    logic [15:0]        bbtime;
    logic [15:0]        srchlvl;
    logic [15:0]        gain;
    logic [15:0]        bias;
    logic [15:0]        lowlim;
    logic               cfg_rej;
    logic [3:0]         ef_lat;
    logic [3:0][1:0]    ef_act;
    logic [3:0][23:0]   hold;
    logic [3:0]         alarm;
    logic               srch_q;
    logic [15:0]        srch_ref;
    daf_pkg::daf_srch_t st;
    logic [15:0]        cnt;
    logic [15:0]        start_f;
    logic [15:0]        sync_f;
    logic               sync_done;
    logic               out_off;
    logic               srch_act;
    logic               relay;
    logic               retry_inh;
    logic               dcb;
    logic               pid_clr;
    logic               pid_byp;
    logic               motor_oh;
    logic [2:0]         stop;
    logic [15:0]        ref_out;
    logic [12:0]        ana_fn;
    logic [15:0]        eff_gain;
    logic [15:0]        eff_bias;
    logic [15:0]        eff_low;
    logic [31:0]        prdata;
    logic               pready;
    logic               pslverr;
  } daf_state_t;

  daf_state_t s_r;
  daf_state_t s_nxt;

  // ==========================================================================
  // per-terminal decode
  logic [3:0]  ef_on;
  logic [3:0]  ef_major;
  logic [3:0]  ef_minor;
  logic [3:0]  dcb_in;
  logic [3:0]  smax_in;
  logic [3:0]  sref_in;
  logic [3:0]  iclr_in;
  logic [3:0]  pidoff_in;
  logic [3:0]  w61;
  logic [3:0]  w62;
  logic [3:0]  coast_hit;
  logic [3:0]  alt_hit;
  logic [31:0] gain_prod;

  for (genvar t = 0; t < 4; t++) begin : g_term
    logic [7:0] fn;
    assign fn = s_r.infunc[t];
    assign ef_on[t] = fn[7:4] >= daf_pkg::EXT_FAULT_CODE_FIRST && fn[7:4] <= daf_pkg::EXT_FAULT_CODE_LAST
                      && (contact[t] ^ fn[daf_pkg::EF_NC_BIT])
                      && (!fn[daf_pkg::EF_RUNONLY_BIT] || running);
    assign ef_minor[t] = ef_on[t] && fn[3:2] == daf_pkg::ACT_MINOR;
    assign ef_major[t] = ef_on[t] && fn[3:2] != daf_pkg::ACT_MINOR;
    assign dcb_in[t] = fn == daf_pkg::FN_DCB && contact[t];
    assign smax_in[t] = fn == daf_pkg::FN_SRCH_MAX && contact[t];
    assign sref_in[t] = fn == daf_pkg::FN_SRCH_REF && contact[t];
    assign iclr_in[t] = fn == daf_pkg::FN_INT_CLR && contact[t];
    assign pidoff_in[t] = fn == daf_pkg::FN_PID_OFF && contact[t];
    assign w61[t] = pwdata[8*t+:8] == daf_pkg::FN_SRCH_MAX;
    assign w62[t] = pwdata[8*t+:8] == daf_pkg::FN_SRCH_REF;
    assign coast_hit[t] = s_nxt.ef_lat[t] && s_nxt.ef_act[t] == daf_pkg::ACT_COAST;
    assign alt_hit[t] = s_nxt.ef_lat[t] && s_nxt.ef_act[t] == daf_pkg::ACT_ALT;
  end

  logic apb_wr;
  logic srch_in;
  logic ana_hi;
  assign apb_wr = psel && penable && s_r.pready && pwrite;
  assign srch_in = |(smax_in | sref_in);
  assign gain_prod = s_r.gain * analog_in;
  assign ana_hi = analog_in > s_r.lowlim;

  // ==========================================================================
  // next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sync_done = 1'b0;

    // register writes
    if (apb_wr) begin
      case (paddr)
        daf_pkg::REG_INFUNC: begin
          s_nxt.cfg_rej = (|w61) && (|w62);
          if (!((|w61) && (|w62))) begin
            s_nxt.infunc = pwdata;
          end
        end
        daf_pkg::REG_ANASEL: s_nxt.anasel = pwdata[3:0];
        daf_pkg::REG_BBTIME: s_nxt.bbtime = pwdata[15:0];
        daf_pkg::REG_SRCHLVL: s_nxt.srchlvl = pwdata[15:0];
        daf_pkg::REG_GAINBIAS: begin
          s_nxt.gain = pwdata[15:0];
          s_nxt.bias = pwdata[31:16];
        end
        daf_pkg::REG_LOWLIM: s_nxt.lowlim = pwdata[15:0];
        default: s_nxt.lowlim = s_r.lowlim;
      endcase
    end

    // external faults; a new fault outranks a reset in the same cycle
    if (fault_reset && baseblock) begin
      s_nxt.ef_lat = 4'h0;
    end
    for (int t = 0; t < 4; t++) begin
      if (ef_major[t]) begin
        s_nxt.ef_lat[t] = 1'b1;
        s_nxt.ef_act[t] = s_r.infunc[t][3:2];
      end
      if (ef_minor[t]) begin
        s_nxt.hold[t] = ALARM_HOLD_CYC;
      end else if (s_r.hold[t] != 24'h0) begin
        s_nxt.hold[t] = s_r.hold[t] - 24'h1;
      end
      s_nxt.alarm[t] = s_nxt.hold[t] != 24'h0;
    end
    s_nxt.relay = |s_nxt.ef_lat;
    if (|coast_hit) begin
      s_nxt.stop = 3'h4;
    end else if (|alt_hit) begin
      s_nxt.stop = 3'h2;
    end else if (|s_nxt.ef_lat) begin
      s_nxt.stop = 3'h1;
    end else begin
      s_nxt.stop = 3'h0;
    end
    s_nxt.retry_inh = |(ef_on | s_r.ef_lat);

    // braking and pid
    s_nxt.dcb = (|dcb_in) && !running && !run_cmd && !jog_cmd;
    s_nxt.pid_clr = |iclr_in;
    s_nxt.pid_byp = (|pidoff_in) && running;
    s_nxt.ref_out = s_nxt.pid_byp ? setpoint : pid_out;

    // speed search; reference captured on search closing, run follows it
    s_nxt.srch_q = srch_in;
    if (srch_in && !s_r.srch_q) begin
      s_nxt.srch_ref = freq_ref;
    end
    case (s_r.st)
      daf_pkg::S_IDLE: begin
        if (power_loss_mode) begin
          s_nxt.start_f = out_freq;
          s_nxt.st = daf_pkg::S_SEARCH;
        end else if (baseblock && run_cmd && srch_in) begin
          s_nxt.start_f = (|smax_in) ? max_freq : s_r.srch_ref;
          s_nxt.cnt = s_r.bbtime;
          s_nxt.st = daf_pkg::S_BBWAIT;
        end
      end
      daf_pkg::S_BBWAIT: begin
        if (s_r.cnt == 16'h0) begin
          s_nxt.st = daf_pkg::S_SEARCH;
        end else begin
          s_nxt.cnt = s_r.cnt - 16'h1;
        end
      end
      daf_pkg::S_SEARCH: begin
        if (out_current < s_r.srchlvl) begin
          s_nxt.sync_f = out_freq;
          s_nxt.sync_done = 1'b1;
          s_nxt.st = daf_pkg::S_IDLE;
        end
      end
      default: s_nxt.st = daf_pkg::S_IDLE;
    endcase
    s_nxt.out_off = s_nxt.st == daf_pkg::S_BBWAIT;
    s_nxt.srch_act = s_nxt.st == daf_pkg::S_SEARCH;

    // analog input; reserved codes fall outside the one-hot range
    s_nxt.ana_fn = 13'h0;
    if (s_r.anasel < 4'(daf_pkg::AN_FN_COUNT)) begin
      s_nxt.ana_fn[s_r.anasel] = 1'b1;
    end
    s_nxt.eff_gain = (s_r.anasel == daf_pkg::AN_GAIN) ? gain_prod[daf_pkg::GAIN_FRAC+:16] : s_r.gain;
    s_nxt.eff_bias = (s_r.anasel == daf_pkg::AN_BIAS1 || s_r.anasel == daf_pkg::AN_BIAS2)
                     ? s_r.bias + analog_in : s_r.bias;
    s_nxt.eff_low = (s_r.anasel == daf_pkg::AN_LOWLIM && ana_hi) ? analog_in : s_r.lowlim;
    // hysteresis band keeps the trip from chattering near threshold
    if (s_r.anasel != daf_pkg::AN_MOTOR_OH || thermistor_ohms <= daf_pkg::THERM_REL_OHM) begin
      s_nxt.motor_oh = 1'b0;
    end else if (thermistor_ohms >= daf_pkg::THERM_TRIP_OHM) begin
      s_nxt.motor_oh = 1'b1;
    end

    // apb: answer prepared in setup, shown for exactly one access cycle
    s_nxt.pready = psel && !penable;
    s_nxt.pslverr = 1'b0;
    s_nxt.prdata = 32'h0;
    if (psel && !penable) begin
      case (paddr)
        daf_pkg::REG_INFUNC: s_nxt.prdata = s_r.infunc;
        daf_pkg::REG_ANASEL: s_nxt.prdata = {28'h0, s_r.anasel};
        daf_pkg::REG_BBTIME: s_nxt.prdata = {16'h0, s_r.bbtime};
        daf_pkg::REG_SRCHLVL: s_nxt.prdata = {16'h0, s_r.srchlvl};
        daf_pkg::REG_GAINBIAS: s_nxt.prdata = {s_r.bias, s_r.gain};
        daf_pkg::REG_LOWLIM: s_nxt.prdata = {16'h0, s_r.lowlim};
        daf_pkg::REG_STATUS: s_nxt.prdata = {18'h0, s_r.st, s_r.motor_oh, s_r.dcb, s_r.cfg_rej, s_r.alarm, s_r.ef_lat};
        daf_pkg::REG_SYNC: s_nxt.prdata = {16'h0, s_r.sync_f};
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
      s_r.st <= daf_pkg::S_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign fault_show = s_r.ef_lat;
  assign alarm_blink = s_r.alarm;
  assign fault_relay = s_r.relay;
  assign stop_sel = s_r.stop;
  assign retry_inhibit = s_r.retry_inh;
  assign dc_brake = s_r.dcb;
  assign output_off = s_r.out_off;
  assign search_active = s_r.srch_act;
  assign search_start_freq = s_r.start_f;
  assign sync_freq = s_r.sync_f;
  assign sync_done = s_r.sync_done;
  assign pid_int_clear = s_r.pid_clr;
  assign pid_bypass = s_r.pid_byp;
  assign freq_ref_out = s_r.ref_out;
  assign analog_fn = s_r.ana_fn;
  assign eff_gain = s_r.eff_gain;
  assign eff_bias = s_r.eff_bias;
  assign eff_low_limit = s_r.eff_low;
  assign motor_overheat = s_r.motor_oh;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  AST_RELAY_NOW: assert property ((|ef_major) |=> fault_relay && (fault_show != 4'h0))
    else $error("fault relay late after major fault");
  AST_ALARM_HOLD: assert property ($rose(ef_minor[3]) |=> alarm_blink[3] [*8])
    else $error("minor alarm shorter than hold");
  AST_RESET_BB: assert property (fault_relay && !baseblock |=> fault_relay)
    else $error("fault cleared outside baseblock");
  AST_STOP_PRIO: assert property ((|fault_show) |-> $onehot(stop_sel))
    else $error("stop method not unique");
  AST_RETRY: assert property ((|ef_on) |=> retry_inhibit)
    else $error("retry allowed during external fault");
  AST_DCB_RUN: assert property ((run_cmd || jog_cmd) |=> !dc_brake)
    else $error("braking kept under run command");
  AST_DCB_ON: assert property ((|dcb_in) && !running && !run_cmd && !jog_cmd |=> dc_brake)
    else $error("braking not started");
  AST_CFG_REJ: assert property (apb_wr && paddr == daf_pkg::REG_INFUNC && (|w61) && (|w62)
                                |=> s_r.infunc == $past(s_r.infunc) && s_r.cfg_rej)
    else $error("conflicting search setup accepted");
  AST_BBWAIT: assert property (s_r.st == daf_pkg::S_BBWAIT && s_r.cnt != 16'h0
                               |=> output_off && !search_active)
    else $error("search began before output-off time");
  AST_SYNC: assert property (search_active && out_current < s_r.srchlvl
                             |=> sync_done && sync_freq == $past(out_freq))
    else $error("sync point not taken");
  AST_THERM: assert property (s_r.anasel == daf_pkg::AN_MOTOR_OH && thermistor_ohms >= daf_pkg::THERM_TRIP_OHM
                              |=> motor_overheat)
    else $error("motor overheat not tripped");
  AST_PIDCLR: assert property ((|iclr_in) |=> pid_int_clear)
    else $error("integral clear missing");
  AST_PID_BYP: assert property ((|pidoff_in) && running
                                |=> pid_bypass && freq_ref_out == $past(setpoint))
    else $error("set-point not passed straight through");
  AST_LOWLIM: assert property (s_r.anasel == daf_pkg::AN_LOWLIM |=> eff_low_limit ==
                               ($past(analog_in) > $past(s_r.lowlim) ? $past(analog_in) : $past(s_r.lowlim)))
    else $error("lower limit not the larger value");
  AST_SRCH_MAX: assert property (s_r.st == daf_pkg::S_IDLE && !power_loss_mode && baseblock && run_cmd && (|smax_in)
                                 |=> output_off && search_start_freq == $past(max_freq))
    else $error("search not started from maximum frequency");
  // ride-through skips the output-off wait entirely
  AST_PWRLOSS: assert property (s_r.st == daf_pkg::S_IDLE && power_loss_mode
                                |=> search_active && search_start_freq == $past(out_freq))
    else $error("ride-through search not from output frequency");

endmodule
`default_nettype wire

// ==== test/daf_motor_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// field contacts and spinning motor load
module daf_motor_model (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic [3:0]  contact_req,
  input  wire logic        run_req,
  input  wire logic        search_active,
  input  wire logic        slow,
  output logic      [3:0]  contact,
  output logic             run_cmd,
  output logic      [15:0] out_current
);
  logic [15:0] step;

  assign contact = contact_req;
  assign step = slow ? 16'h000A : 16'h0028;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_cmd <= 1'b0;
      out_current <= 16'h0000;
    end else begin
      // run trails the contacts by a cycle, never leads search
      run_cmd <= run_req;
      // load stays high until the search starts, then falls by step each cycle
      if (!search_active) begin
        out_current <= 16'h0190;
      end else if (out_current > step) begin
        out_current <= out_current - step;
      end else begin
        out_current <= 16'h0000;
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// bench top
module tb_top;
  localparam logic [23:0] HOLD = 24'h000010;
  localparam logic [15:0] BB = 16'h0003;
  logic        clock = 1'b0;
  logic        rstn, psel, penable, pwrite, running, jog_cmd, baseblock, fault_reset;
  logic        power_loss_mode, run_req, slow, pready, pslverr, fault_relay, er, th;
  logic        retry_inhibit, dc_brake, output_off, search_active, sync_done;
  logic        pid_int_clear, pid_bypass, motor_overheat, run_cmd;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  contact, contact_req, fault_show, alarm_blink;
  logic [2:0]  stop_sel;
  logic [12:0] analog_fn;
  logic [15:0] out_current, out_freq, freq_ref, max_freq, setpoint, pid_out, analog_in;
  logic [15:0] thermistor_ohms, search_start_freq, sync_freq, freq_ref_out, ga, bi, lo;
  logic [15:0] eff_gain, eff_bias, eff_low_limit;
  logic [3:0]  cs[3] = '{4'h6, 4'h4, 4'h0};
  logic [2:0]  ss[3] = '{3'h2, 3'h1, 3'h0};
  logic [15:0] dv[2] = '{16'hFFFF, 16'h0001};
  int          ohm_q[$] = '{1329, 1330, 900, 551, 550, 1000, 1400};
  int          miscompares, n_compared, cyc_cnt, off_cnt;

  daf_aux_top #(.ALARM_HOLD_CYC(HOLD)) dut (
    .clock, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .contact, .running, .run_cmd, .jog_cmd, .baseblock, .fault_reset, .power_loss_mode,
    .out_current, .out_freq, .freq_ref, .max_freq, .setpoint, .pid_out, .analog_in,
    .thermistor_ohms, .fault_show, .alarm_blink, .fault_relay, .stop_sel, .retry_inhibit,
    .dc_brake, .output_off, .search_active, .search_start_freq, .sync_freq, .sync_done,
    .pid_int_clear, .pid_bypass, .freq_ref_out, .analog_fn, .eff_gain, .eff_bias,
    .eff_low_limit, .motor_overheat
  );
  daf_motor_model fld (
    .clock, .rstn, .contact_req, .run_req, .search_active, .slow, .contact, .run_cmd, .out_current
  );

  always #25 clock = ~clock;
  always @(negedge clock) off_cnt += int'(output_off === 1'b1);
  // hang guard: the whole sequence needs well under 3000 cycles
  always @(posedge clock) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic srch(input logic [7:0] code, input logic pl, input logic sl);
    logic [15:0] exp;
    int k;
    apb(1'b1, daf_pkg::REG_INFUNC, {24'h000000, code});
    @(posedge clock);
    max_freq <= 16'($urandom);
    freq_ref <= 16'($urandom);
    out_freq <= 16'($urandom);
    baseblock <= ~pl;
    power_loss_mode <= pl;
    slow <= sl;
    @(posedge clock);
    contact_req <= {3'h0, ~pl};
    run_req <= ~pl;
    off_cnt = 0;
    exp = pl ? out_freq : (code == daf_pkg::FN_SRCH_MAX ? max_freq : freq_ref);
    repeat (3) @(posedge clock);
    freq_ref <= ~freq_ref;
    k = 0;
    while (sync_done !== 1'b1 && k < 300) begin
      @(negedge clock);
      k++;
    end
    chk(sync_done, 32'h1);
    chk(search_active, 32'h0);
    chk(sync_freq, out_freq);
    chk(search_start_freq, exp);
    chk(32'(off_cnt), pl ? 32'h0 : 32'(BB) + 32'h1);
    @(posedge clock);
    contact_req <= 4'h0;
    run_req <= 1'b0;
    baseblock <= 1'b0;
    power_loss_mode <= 1'b0;
    w(60);
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    {rstn, psel, penable, pwrite, running, run_req, jog_cmd, baseblock, fault_reset} = '0;
    {power_loss_mode, slow, paddr, pwdata, contact_req, out_freq, freq_ref} = '0;
    {max_freq, setpoint, pid_out, analog_in, thermistor_ohms} = '0;
    void'($urandom(32'h3124));
    repeat (20) @(posedge clock);
    chk(fault_relay, 32'h0);
    @(posedge clock);
    rstn <= 1'b1;
    w(2);
    chk(analog_fn, 32'h1);
    $display("reset done");
    apb(1'b1, daf_pkg::REG_INFUNC, 32'h5C403824);
    @(posedge clock);
    contact_req <= 4'h7;
    w(1);
    chk(fault_show, 32'h7);
    chk(fault_relay, 32'h1);
    chk(stop_sel, 32'h4);
    chk(retry_inhibit, 32'h1);
    @(posedge clock);
    fault_reset <= 1'b1;
    contact_req <= 4'h6;
    w(2);
    chk(fault_show, 32'h7);
    @(posedge clock);
    baseblock <= 1'b1;
    foreach (cs[i]) begin
      @(posedge clock);
      contact_req <= cs[i];
      w(2);
      chk(fault_show, cs[i]);
      chk(stop_sel, ss[i]);
    end
    chk(retry_inhibit, 32'h0);
    @(posedge clock);
    fault_reset <= 1'b0;
    baseblock <= 1'b0;
    contact_req <= 4'h8;
    @(posedge clock);
    contact_req <= 4'h0;
    w(0);
    chk({fault_show, alarm_blink}, 32'h08);
    w(32'(HOLD) - 2);
    chk(alarm_blink, 32'h8);
    w(10);
    chk(alarm_blink, 32'h0);
    $display("faults done");
    apb(1'b1, daf_pkg::REG_BBTIME, {16'h0000, BB});
    apb(1'b1, daf_pkg::REG_SRCHLVL, 32'h00000064);
    srch(daf_pkg::FN_SRCH_MAX, 1'b0, 1'b0);
    srch(daf_pkg::FN_SRCH_REF, 1'b0, 1'b1);
    srch(daf_pkg::FN_SRCH_MAX, 1'b1, 1'b0);
    apb(1'b1, daf_pkg::REG_INFUNC, 32'h00006261);
    apb(1'b0, daf_pkg::REG_STATUS, 32'h0);
    chk(rd[8], 32'h1);
    apb(1'b0, daf_pkg::REG_INFUNC, 32'h0);
    chk(rd, 32'h61);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 32'h1);
    chk(rd, 32'h0);
    $display("search done");
    apb(1'b1, daf_pkg::REG_INFUNC, 32'h00000060);
    @(posedge clock);
    contact_req <= 4'h1;
    w(1);
    chk(dc_brake, 32'h1);
    @(posedge clock);
    run_req <= 1'b1;
    w(2);
    chk(dc_brake, 32'h0);
    @(posedge clock);
    run_req <= 1'b0;
    jog_cmd <= 1'b1;
    w(3);
    chk(dc_brake, 32'h0);
    @(posedge clock);
    jog_cmd <= 1'b0;
    w(1);
    chk(dc_brake, 32'h1);
    apb(1'b1, daf_pkg::REG_INFUNC, 32'h00006665);
    @(posedge clock);
    running <= 1'b1;
    setpoint <= 16'($urandom);
    contact_req <= 4'h1;
    w(1);
    chk({pid_int_clear, pid_bypass}, 32'h2);
    @(posedge clock);
    contact_req <= 4'h2;
    w(1);
    chk({pid_int_clear, pid_bypass}, 32'h1);
    chk(freq_ref_out, setpoint);
    @(posedge clock);
    contact_req <= 4'h0;
    running <= 1'b0;
    $display("contacts done");
    for (int s = 0; s < 16; s++) begin
      apb(1'b1, daf_pkg::REG_ANASEL, 32'(s));
      w(2);
      chk(analog_fn, s < 13 ? 32'h1 << s : 32'h0);
    end
    ga = 16'($urandom);
    bi = 16'($urandom);
    lo = 16'h4000 + 16'($urandom & 32'hFFF);
    apb(1'b1, daf_pkg::REG_GAINBIAS, {bi, ga});
    apb(1'b1, daf_pkg::REG_LOWLIM, {16'h0000, lo});
    @(posedge clock);
    analog_in <= 16'($urandom);
    apb(1'b1, daf_pkg::REG_ANASEL, 32'h1);
    w(2);
    chk(eff_gain, 16'((32'(ga) * 32'(analog_in)) >> 12));
    for (int s = 2; s < 4; s++) begin
      apb(1'b1, daf_pkg::REG_ANASEL, 32'(s));
      w(2);
      chk(eff_bias, 16'(bi + analog_in));
    end
    apb(1'b1, daf_pkg::REG_ANASEL, 32'hA);
    foreach (dv[i]) begin
      @(posedge clock);
      analog_in <= lo + dv[i];
      w(2);
      chk(eff_low_limit, lo > analog_in ? lo : analog_in);
    end
    apb(1'b1, daf_pkg::REG_ANASEL, 32'hC);
    th = 1'b0;
    while (ohm_q.size() > 0) begin
      @(posedge clock);
      thermistor_ohms <= 16'(ohm_q[0]);
      th = ohm_q[0] >= 1330 ? 1'b1 : (ohm_q[0] <= 550 ? 1'b0 : th);
      void'(ohm_q.pop_front());
      w(2);
      chk(motor_overheat, th);
    end
    $display("analog done");
    print_verdict();
  end
endmodule
`default_nettype wire
